/* logic/dis_bank.v */
// Pattern generator and timing bank reached through the indirect window
`timescale 1ns/10ps
`include "dis_regs.vh"
module dis_bank (
  input wire sys_clk, // System clock
  input wire rst, // Asynchronous reset, active high
  input wire [7:0] bank_addr, // Register offset inside the bank
  input wire bank_wr, // Write strobe
  input wire [7:0] bank_wdata, // Write data
  input wire bank_rd, // Read strobe, loads the prefetch register
  output reg [7:0] bank_rdata // Prefetched read data
);
  reg [7:0] mem [0:255];
  integer i;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < 256; i = i + 1) begin
        mem[i] <= 8'h00;
      end
      bank_rdata <= `DIS_RST_IND_DATA;
    end else begin
      if (bank_wr) begin
        mem[bank_addr] <= bank_wdata;
      end
      // Write-through keeps a read strobe in the same cycle coherent
      if (bank_rd) begin
        bank_rdata <= bank_wr ? bank_wdata : mem[bank_addr];
      end
    end
  end
endmodule // dis_bank

/* logic/dis_refclk.v */
// Reference clock frequency meter: counts synchronised rising edges per microsecond
`timescale 1ns/10ps
`include "dis_regs.vh"
module dis_refclk (
  input wire sys_clk, // System clock
  input wire rst, // Asynchronous reset, active high
  input wire ref_clk_in, // Reference clock pin, sampled
  output reg [7:0] ref_mhz // Measured frequency in MHz
);
  // One microsecond window at the system clock rate
  localparam [7:0] WIN_CYC = `DIS_REFCLK_WIN_CYC;
  reg s1, s2, s3;
  reg [7:0] win_cnt;
  reg [7:0] edge_cnt;
  wire rise = s2 & ~s3;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      win_cnt <= 8'h00;
      edge_cnt <= 8'h00;
      ref_mhz <= 8'h00;
    end else begin
      s1 <= ref_clk_in;
      s2 <= s1;
      s3 <= s2;
      // Only clocks below half the sampling rate can be measured
      if (win_cnt == WIN_CYC - 8'h01) begin
        win_cnt <= 8'h00;
        ref_mhz <= edge_cnt + {7'h00, rise}; // [R4]
        edge_cnt <= 8'h00;
      end else begin
        win_cnt <= win_cnt + 8'h01;
        edge_cnt <= edge_cnt + {7'h00, rise};
      end
    end
  end
endmodule // dis_refclk

/* logic/dis_regs.vh */
// Register offsets, field positions and reset values for the diagnostic register segment
// Behaviour
// [R1] Reading the line error high byte returns bits 15:8 of the 16-bit line error count.
// [R2] That same read snapshots bits 7:0 into the low byte register and clears the counter.
// [R3] The low byte register returns the snapshot, so software reads the high byte first.
// [R4] A read-only 8-bit field gives the measured reference clock frequency in MHz.
// [R5] A 4-bit target select picks the indirect bank, where 0000 is the pattern and timing bank and others are reserved.
// [R6] With auto-increment set, the indirect offset steps by one after each completed indirect read or write.
// [R7] With prefetch set, a write of the indirect offset register issues a read strobe to the selected bank.
// [R8] With both auto-increment and prefetch set, a read strobe also follows each host read of the data register.
// [R9] The indirect offset register holds an 8-bit offset and resets to 0x3a.
// [R10] A host write of the data register writes that byte into the selected bank at the current offset.
// [R11] A host read of the data register returns the selected bank's register at the current offset. Here it returns the last prefetched byte.
// [R12] Software must not rely on the data register's nominal reset value, which may vary between devices.
// [R13] The output mode field selects no toggling for 00, alternating toggling for 01 and data-driven toggling for 1x.
// [R14] With the configuration bit at zero the self-test is configured from bits 2:0; the value one is reserved. Here it is fixed at one.
// [R15] Once self-test is enabled the 2-bit clock source is written to remote offset 0x14; clearing enable stops it.
// [R16] The line error counter counts each errored line and saturates at its 16-bit maximum.
// [R17] Offset auto-increment wraps from 0xff to 0x00 without touching the target select.
`ifndef DIS_REGS_VH
`define DIS_REGS_VH
`define DIS_OFS_LERR_HI 8'h96
`define DIS_OFS_LERR_LO 8'h97
`define DIS_OFS_REFCLK 8'ha5
`define DIS_OFS_IND_CTL 8'hb0
`define DIS_OFS_IND_OFS 8'hb1
`define DIS_OFS_IND_DATA 8'hb2
`define DIS_OFS_BIST 8'hb3
`define DIS_RST_IND_CTL 8'h1c
`define DIS_RST_IND_CTL_BITS 6'h1c
`define DIS_RST_IND_OFS 8'h3a
`define DIS_RST_IND_DATA 8'h14
`define DIS_RST_BIST 8'h08
`define DIS_SEL_PATGEN 4'h0
`define DIS_IND_SEL_MSB 5
`define DIS_IND_SEL_LSB 2
`define DIS_IND_INC_BIT 1
`define DIS_IND_RD_BIT 0
`define DIS_BIST_MODE_MSB 7
`define DIS_BIST_MODE_LSB 6
`define DIS_BIST_CFG_BIT 3
`define DIS_BIST_CSRC_MSB 2
`define DIS_BIST_CSRC_LSB 1
`define DIS_BIST_EN_BIT 0
`define DIS_BIST_MODE_NONE 2'h0
`define DIS_BIST_MODE_ALT 2'h1
`define DIS_REMOTE_CSRC_OFS 8'h14
`define DIS_CNT_MAX 16'hffff
`define DIS_REFCLK_WIN_US 1
`define DIS_SYS_MHZ 100
`define DIS_REFCLK_WIN_CYC 8'd100
`endif

/* logic/dis_top.v */
// Diagnostic register segment: line error counter, reference clock meter, indirect window, self-test control
//
// Our own choice: register access over Wishbone.
`timescale 1ns/10ps
`include "dis_regs.vh"
module dis_top (
  input wire sys_clk, // System clock, 100 MHz
  input wire rst, // Asynchronous reset, active high
  input wire wb_cyc_i, // Wishbone cycle
  input wire wb_stb_i, // Wishbone strobe
  input wire wb_we_i, // Wishbone write enable
  input wire [9:0] wb_adr_i, // Wishbone byte address
  input wire [3:0] wb_sel_i, // Wishbone byte selects
  input wire [31:0] wb_dat_i, // Wishbone write data
  output reg [31:0] wb_dat_o, // Wishbone read data
  output reg wb_ack_o, // Wishbone acknowledge
  input wire line_error_pulse, // One-cycle pulse per errored output line
  input wire ref_clk_in, // Reference clock pin
  output reg [1:0] self_test_mode, // Output toggle pattern selection
  output wire self_test_enable, // Self-test running
  output reg remote_wr, // Pulse: write to remote serializer
  output reg [7:0] remote_addr, // Remote register offset
  output reg [7:0] remote_wdata // Remote write data
);
  reg [15:0] output_line_error_counter;
  reg [7:0] line_error_count_low;
  reg [5:0] ctl_bits;
  reg [7:0] indirect_offset;
  reg [7:0] bist;
  reg bist_en_d;
  reg bank_wr;
  reg [7:0] bank_wdata;
  reg bank_rd;
  reg [7:0] bank_addr;
  wire [7:0] bank_rdata;
  wire [7:0] reference_clock_mhz;

  wire [7:0] reg_idx = wb_adr_i[9:2];
  wire access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_lane = wb_we_i & wb_sel_i[0];
  wire rd_hi = access & ~wb_we_i & (reg_idx == `DIS_OFS_LERR_HI);
  wire wr_ctl = access & wr_lane & (reg_idx == `DIS_OFS_IND_CTL);
  wire wr_ofs = access & wr_lane & (reg_idx == `DIS_OFS_IND_OFS);
  wire wr_data = access & wr_lane & (reg_idx == `DIS_OFS_IND_DATA);
  wire rd_data = access & ~wb_we_i & (reg_idx == `DIS_OFS_IND_DATA);
  wire wr_bist = access & wr_lane & (reg_idx == `DIS_OFS_BIST);
  wire [3:0] indirect_target_select = ctl_bits[`DIS_IND_SEL_MSB:`DIS_IND_SEL_LSB];
  wire indirect_offset_step_enable = ctl_bits[`DIS_IND_INC_BIT];
  wire indirect_prefetch_enable = ctl_bits[`DIS_IND_RD_BIT];
  wire target_ok = (indirect_target_select == `DIS_SEL_PATGEN); // [R5]
  wire [7:0] indirect_control = {2'b00, ctl_bits};
  wire [7:0] indirect_data_value = target_ok ? bank_rdata : 8'h00;

  // Line error counter with read-to-clear snapshot
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      output_line_error_counter <= 16'h0000;
      line_error_count_low <= 8'h00;
    end else if (rd_hi) begin
      line_error_count_low <= output_line_error_counter[7:0]; // [R2]
      // An error in the clearing cycle is kept, not lost
      output_line_error_counter <= {15'h0000, line_error_pulse}; // [R2]
    end else if (line_error_pulse && output_line_error_counter != `DIS_CNT_MAX) begin
      output_line_error_counter <= output_line_error_counter + 16'h0001; // [R16]
    end
  end

  // Indirect window control, offset, strobes
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl_bits <= `DIS_RST_IND_CTL_BITS;
      indirect_offset <= `DIS_RST_IND_OFS; // [R9]
      bank_wr <= 1'b0;
      bank_rd <= 1'b0;
      bank_wdata <= 8'h00;
      bank_addr <= 8'h00;
    end else begin
      bank_wr <= 1'b0;
      bank_rd <= 1'b0;
      if (wr_ctl) begin
        ctl_bits <= wb_dat_i[5:0];
      end
      if (wr_ofs) begin
        indirect_offset <= wb_dat_i[7:0];
        bank_addr <= wb_dat_i[7:0];
        bank_rd <= indirect_prefetch_enable & target_ok; // [R7]
      end
      if (wr_data && target_ok) begin
        bank_wr <= 1'b1; // [R10]
        bank_wdata <= wb_dat_i[7:0];
        bank_addr <= indirect_offset;
      end
      if ((wr_data || rd_data) && indirect_offset_step_enable) begin
        indirect_offset <= indirect_offset + 8'h01; // [R6] [R17]
      end
      if (rd_data && indirect_offset_step_enable && indirect_prefetch_enable && target_ok) begin
        bank_addr <= indirect_offset + 8'h01;
        bank_rd <= 1'b1; // [R8]
      end
      if (wr_data && target_ok && indirect_prefetch_enable) begin
        // Refresh the prefetch with the written byte
        bank_rd <= 1'b1;
      end
    end
  end

  // Self-test control; a rising enable posts the clock source to the remote side
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bist <= `DIS_RST_BIST;
      bist_en_d <= 1'b0;
      self_test_mode <= `DIS_BIST_MODE_NONE;
      remote_wr <= 1'b0;
      remote_addr <= 8'h00;
      remote_wdata <= 8'h00;
    end else begin
      if (wr_bist) begin
        // Bits 5:3 are read-only; configuration bit stays one
        bist <= {wb_dat_i[7:6], bist[5:3], wb_dat_i[2:0]}; // [R14]
      end
      bist_en_d <= bist[`DIS_BIST_EN_BIT];
      self_test_mode <= bist[`DIS_BIST_MODE_MSB:`DIS_BIST_MODE_LSB]; // [R13]
      remote_wr <= bist[`DIS_BIST_EN_BIT] & ~bist_en_d; // [R15]
      if (bist[`DIS_BIST_EN_BIT] && !bist_en_d) begin
        remote_addr <= `DIS_REMOTE_CSRC_OFS; // [R15]
        remote_wdata <= {6'h00, bist[`DIS_BIST_CSRC_MSB:`DIS_BIST_CSRC_LSB]};
      end
    end
  end
  assign self_test_enable = bist[`DIS_BIST_EN_BIT] & ~bist[`DIS_BIST_CFG_BIT]; // [R14] [R15]

  // Wishbone read mux and single-wait acknowledge
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= access;
      if (access && !wb_we_i) begin
        case (reg_idx)
          `DIS_OFS_LERR_HI: wb_dat_o <= {24'h000000, output_line_error_counter[15:8]}; // [R1]
          `DIS_OFS_LERR_LO: wb_dat_o <= {24'h000000, line_error_count_low}; // [R3]
          `DIS_OFS_REFCLK: wb_dat_o <= {24'h000000, reference_clock_mhz}; // [R4]
          `DIS_OFS_IND_CTL: wb_dat_o <= {24'h000000, indirect_control};
          `DIS_OFS_IND_OFS: wb_dat_o <= {24'h000000, indirect_offset};
          `DIS_OFS_IND_DATA: wb_dat_o <= {24'h000000, indirect_data_value}; // [R11]
          `DIS_OFS_BIST: wb_dat_o <= {24'h000000, bist};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  dis_bank u_bank (
    .sys_clk(sys_clk),
    .rst(rst),
    .bank_addr(bank_addr),
    .bank_wr(bank_wr),
    .bank_wdata(bank_wdata),
    .bank_rd(bank_rd),
    .bank_rdata(bank_rdata)
  );

  dis_refclk u_refclk (
    .sys_clk(sys_clk),
    .rst(rst),
    .ref_clk_in(ref_clk_in),
    .ref_mhz(reference_clock_mhz)
  );
endmodule // dis_top

/* sim/dis_top_asserts.sv */
// Concurrent checks on the diagnostic register segment ports
`timescale 1ns/10ps
module dis_top_chk (
  input wire sys_clk, // Clock
  input wire rst, // Reset
  input wire wb_cyc_i, // Cycle
  input wire wb_stb_i, // Strobe
  input wire wb_we_i, // Write
  input wire [9:0] wb_adr_i, // Address
  input wire [3:0] wb_sel_i, // Selects
  input wire [31:0] wb_dat_i, // Write data
  input wire [31:0] wb_dat_o, // Read data
  input wire wb_ack_o, // Ack
  input wire [1:0] self_test_mode, // Mode
  input wire self_test_enable, // Enable
  input wire remote_wr, // Remote strobe
  input wire [7:0] remote_addr, // Remote offset
  input wire [7:0] remote_wdata // Remote data
);
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_st = take && wb_we_i && wb_sel_i[0] && wb_adr_i == 10'h2cc;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_ack_next;
    take |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_unmapped;
    take && !wb_we_i && wb_adr_i == 10'h000 |=> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_remote_addr;
    remote_wr |-> remote_addr == 8'h14;
  endproperty
  a_remote_addr: assert property (p_remote_addr) else $error("remote offset wrong");
  property p_remote_cause;
    remote_wr |-> $past(wr_st && wb_dat_i[0], 2) && remote_wdata[1:0] == $past(wb_dat_i[2:1], 2);
  endproperty
  a_remote_cause: assert property (p_remote_cause) else $error("remote write unexpected");
  property p_remote_pulse;
    remote_wr |=> !remote_wr;
  endproperty
  a_remote_pulse: assert property (p_remote_pulse) else $error("remote strobe long");
  property p_mode_copy;
    wr_st |-> ##2 self_test_mode == $past(wb_dat_i[7:6], 2);
  endproperty
  a_mode_copy: assert property (p_mode_copy) else $error("mode not applied");
  property p_test_off;
    !self_test_enable;
  endproperty
  a_test_off: assert property (p_test_off) else $error("test enabled");
endmodule // dis_top_chk
bind dis_top dis_top_chk u_chk (.*);

/* sim/dis_top_tb.sv */
// Self-checking bench for the diagnostic register segment
`timescale 1ns/10ps
module dis_top_tb_top;
  logic sys_clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, lep = 0, rck = 0;
  logic [9:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, self_test_enable, remote_wr;
  wire [1:0] self_test_mode;
  wire [7:0] remote_addr, remote_wdata;
  int bad_count = 0, check_count = 0, cyc_n = 0;
  always #5 sys_clk = ~sys_clk;
  // 20 MHz reference, offset so its edges never meet the system clock
  initial #2 forever #25 rck = ~rck;
  dis_top u_dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .line_error_pulse(lep), .ref_clk_in(rck),
    .self_test_mode(self_test_mode), .self_test_enable(self_test_enable), .remote_wr(remote_wr),
    .remote_addr(remote_addr), .remote_wdata(remote_wdata));
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wb(bit w, logic [7:0] o, logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= {o, 2'b00}; wb_dat_i <= {24'h0, d};
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 0; wb_stb_i <= 0;
  endtask
  task automatic wr(logic [7:0] o, logic [7:0] d);
    logic [7:0] q;
    wb(1, o, d, q);
  endtask
  task automatic rd(logic [7:0] o, logic [7:0] e);
    logic [7:0] q;
    wb(0, o, 8'h0, q);
    chk($sformatf("reg %h", o), e, q);
  endtask
  task automatic t_reset;
    rd(8'hb0, 8'h1c);
    rd(8'hb1, 8'h3a);
    rd(8'hb2, 8'h00);
    rd(8'hb3, 8'h08);
    rd(8'h96, 8'h00);
    rd(8'h00, 8'h00);
  endtask
  task automatic t_lerr;
    repeat (261) begin
      @(posedge sys_clk) lep <= 1;
      @(posedge sys_clk) lep <= 0;
    end
    rd(8'h96, 8'h01);
    rd(8'h97, 8'h05);
    rd(8'h96, 8'h00);
    @(posedge sys_clk) lep <= 1;
    repeat (65540) @(posedge sys_clk);
    lep <= 0;
    rd(8'h96, 8'hff);
    rd(8'h97, 8'hff);
  endtask
  task automatic t_ind;
    wr(8'hb0, 8'h02);
    wr(8'hb1, 8'h10);
    wr(8'hb2, 8'ha5);
    wr(8'hb2, 8'h5a);
    rd(8'hb1, 8'h12);
    wr(8'hb0, 8'h03);
    wr(8'hb1, 8'h10);
    repeat (2) @(posedge sys_clk);
    rd(8'hb2, 8'ha5);
    repeat (2) @(posedge sys_clk);
    rd(8'hb2, 8'h5a);
    wr(8'hb0, 8'h02);
    wr(8'hb1, 8'hff);
    wr(8'hb2, 8'h11);
    rd(8'hb1, 8'h00);
    rd(8'hb0, 8'h02);
  endtask
  task automatic t_refclk;
    repeat (300) @(posedge sys_clk);
    rd(8'ha5, 8'd20);
  endtask
  task automatic t_bist;
    logic [7:0] d;
    for (int m = 0; m < 4; m++) begin
      d = 8'(m << 6) | 8'(m << 1) | 8'h01;
      wr(8'hb3, d);
      for (int i = 0; i < 4 && remote_wr !== 1'b1; i++) @(posedge sys_clk);
      chk("remote strobe", 8'h01, {7'h0, remote_wr});
      chk("remote offset", 8'h14, remote_addr);
      chk("remote source", 8'(m), {6'h0, remote_wdata[1:0]});
      repeat (2) @(posedge sys_clk);
      chk("mode", 8'(m), {6'h0, self_test_mode});
      chk("enable", 8'h00, {7'h0, self_test_enable});
      rd(8'hb3, d | 8'h08);
      // Enable must fall so the next pass sees a fresh rising edge
      wr(8'hb3, 8'h00);
      repeat (2) @(posedge sys_clk);
      chk("disabled", 8'h00, {7'h0, self_test_enable});
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc_n++;
    if (cyc_n == 90000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 0;
    t_reset();
    t_ind();
    t_refclk();
    t_bist();
    t_lerr();
    wrap_up();
  end
endmodule // dis_top_tb_top
